// ==== design/bus_low_timer.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "rpi_defines.svh"
// ****************************************
// Serial-bus held-low reset timer
// ****************************************
module bus_low_timer
  import rpi_pkg::*;
#(
  parameter rpi_pkg::timer_cnt_t CYCLES = rpi_pkg::timer_cnt_t'(`BUS_LOW_RESET_CYCLES)
) (
  input wire logic ref_clk, // System clock
  input wire logic resetn, // Synchronous reset, active low
  input wire logic both_low, // Clock and data both low, synchronised
  output logic fire // One-cycle reset request
);
  bus_timer_s st_r;
  bus_timer_s st_nxt;

  // Fires once per low stretch; any high level restarts the count
  always_comb
  begin
    st_nxt = st_r;
    if (!both_low)
    begin
      st_nxt.cnt = '0;
      st_nxt.fired = 1'b0;
    end
    else if (!st_r.fired)
    begin
      if (st_r.cnt == CYCLES - 1'b1)
        st_nxt.fired = 1'b1;
      else
        st_nxt.cnt = st_r.cnt + 1'b1;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign fire = both_low & ~st_r.fired & (st_r.cnt == CYCLES - 1'b1);

  a_release_restarts: assert property (@(posedge ref_clk) disable iff (!resetn)
    !both_low |=> st_r.cnt == '0) else $error("bus low count not restarted");
  a_fire_once: assert property (@(posedge ref_clk) disable iff (!resetn)
    fire |=> !fire [*3]) else $error("bus low reset fired twice");
endmodule : bus_low_timer
`default_nettype wire

// ==== design/pin_sync.sv ====
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Two-stage synchroniser, one per bit
// ****************************************
module pin_sync #(
  parameter int W = 7
) (
  input wire logic ref_clk, // System clock
  input wire logic resetn, // Synchronous reset, active low
  input wire logic [W-1:0] async_in, // Pins from outside the domain
  output logic [W-1:0] sync_out // Safe to read
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } sync_s;

  sync_s st_r;
  sync_s st_nxt;

  // First stage feeds only the second stage
  for (genvar i = 0; i < W; i++)
  begin : g_bit
    assign st_nxt.meta[i] = async_in[i];
    assign st_nxt.sync[i] = st_r.meta[i];
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign sync_out = st_r.sync;
endmodule : pin_sync
`default_nettype wire

// ==== design/reset_power_interrupt_core.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "rpi_defines.svh"
module reset_power_interrupt_core #(
  parameter rpi_pkg::timer_cnt_t BUS_LOW_CYCLES = rpi_pkg::timer_cnt_t'(`BUS_LOW_RESET_CYCLES)
) (
  input wire logic ref_clk, // 50 MHz clock
  input wire logic resetn, // Power-up reset, active low
  input wire rpi_pkg::supply_pins_s pins, // Asynchronous pins
  input wire logic id_code_change, // Resistor code changed, pulse
  input wire logic usb_discovery_done, // Discovery finished, level
  input wire logic usb_route_req, // Automatic routing wants host one
  input wire rpi_pkg::reg_req_s reg_req, // Register access from serial slave
  output logic [7:0] reg_rdata, // Read data, registered
  output logic reg_rvalid, // Read data valid, pulse
  output logic irq_out_n, // Interrupt, active low, push-pull
  output rpi_pkg::power_state_s power, // Enabled functions
  output rpi_pkg::switch_ctrl_s switches, // Switch drives
  output logic standby, // No accessory attached
  output logic hw_reset_pulse // Hardware reset taken
);
  import rpi_pkg::*;

  // ****************************************
  // Reset image and state
  // ****************************************
  localparam core_state_s CORE_RESET = '{
    ctrl: `CTRL_RESET,
    flags: `FLAGS_RESET,
    mansw: `MANSW_RESET,
    chg: `CHG_RESET,
    mic: `MIC_RESET,
    state: ST_STANDBY,
    prev: '0,
    rdata: 8'h00,
    rvalid: 1'b0,
    soft_pulse: 1'b0
  };

  core_state_s st_r;
  core_state_s st_nxt;
  supply_pins_s pins_s;
  logic bus_low_fire;
  logic por_edge;
  logic io_fall;
  logic hw_rst;
  logic attach_now;
  logic man_active;
  logic [7:0] ev;

  // ****************************************
  // Pin synchronisation and bus-low timer
  // ****************************************
  pin_sync #(
    .W($bits(supply_pins_s))
  ) u_sync (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .async_in(pins),
    .sync_out(pins_s)
  );

  // Long count kept in its own module so a bench can shorten it
  bus_low_timer #(
    .CYCLES(BUS_LOW_CYCLES)
  ) u_bus_low (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .both_low(~pins_s.scl & ~pins_s.sda),
    .fire(bus_low_fire)
  );

  // ****************************************
  // Hardware reset sources
  // ****************************************
  // Edge history survives internal resets, so a reset cannot retrigger itself
  assign por_edge = (pins_s.cable_valid & ~st_r.prev.cable_valid & pins_s.battery_low)
    | (pins_s.battery_valid & ~st_r.prev.battery_valid & ~pins_s.cable_valid);
  assign io_fall = ~pins_s.io_valid & st_r.prev.io_valid;
  assign hw_rst = por_edge | io_fall | bus_low_fire;

  // ****************************************
  // Supply states
  // ****************************************
  always_comb
  begin
    power.charge_enable = pins_s.cable_valid & ~st_r.chg[`CHG_INHIBIT_BIT];
    power.detect_enable = pins_s.cable_valid | pins_s.battery_valid;
    power.comm_enable = pins_s.io_valid & power.detect_enable;
    power.illegal_supply = pins_s.io_valid & ~power.detect_enable;
    power.cable_powered = pins_s.cable_valid & ~pins_s.battery_valid;
  end

  // Attach seen from either the id pin or the cable supply
  assign attach_now = power.detect_enable & (~pins_s.id_float | pins_s.cable_valid);

  // Status change events
  always_comb
  begin
    ev = 8'h00;
    ev[`FLAG_ATTACH_BIT] = attach_now & (st_r.state == ST_STANDBY);
    ev[`FLAG_DETACH_BIT] = ~attach_now & (st_r.state == ST_ATTACHED);
    ev[`FLAG_VBUS_CHG_BIT] = pins_s.cable_valid ^ st_r.prev.cable_valid;
    ev[`FLAG_ID_CHG_BIT] = (pins_s.id_float ^ st_r.prev.id_float) | id_code_change;
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.prev = pins_s;
    st_nxt.rvalid = 1'b0;
    st_nxt.soft_pulse = 1'b0;
    // Attach tracking; standby is the idle watch state
    case (st_r.state)
      ST_STANDBY:
        if (attach_now)
          st_nxt.state = ST_ATTACHED;
      ST_ATTACHED:
        if (!attach_now)
          st_nxt.state = ST_STANDBY;
      default:
        st_nxt.state = ST_STANDBY;
    endcase
    // Reads; the flag register clears on read
    if (power.comm_enable && reg_req.rd)
    begin
      st_nxt.rvalid = 1'b1;
      case (reg_req.addr)
        `ADDR_CONTROL: st_nxt.rdata = st_r.ctrl;
        `ADDR_INT_FLAGS:
        begin
          st_nxt.rdata = st_r.flags;
          st_nxt.flags = `FLAGS_RESET;
        end
        `ADDR_MANUAL_SWITCH: st_nxt.rdata = st_r.mansw;
        `ADDR_CHARGE_MANUAL: st_nxt.rdata = st_r.chg;
        `ADDR_MIC_CONFIG: st_nxt.rdata = st_r.mic;
        default: st_nxt.rdata = 8'h00;
      endcase
    end
    // Writes; the soft reset bit is a trigger and never stored
    if (power.comm_enable && reg_req.wr)
    begin
      case (reg_req.addr)
        `ADDR_CONTROL:
        begin
          st_nxt.ctrl = reg_req.wdata;
          st_nxt.ctrl[`CTRL_SOFT_RESET_BIT] = 1'b0;
          st_nxt.soft_pulse = reg_req.wdata[`CTRL_SOFT_RESET_BIT];
        end
        `ADDR_MANUAL_SWITCH: st_nxt.mansw = reg_req.wdata;
        `ADDR_CHARGE_MANUAL: st_nxt.chg = reg_req.wdata;
        `ADDR_MIC_CONFIG: st_nxt.mic = reg_req.wdata;
        default: st_nxt.mic = st_nxt.mic;
      endcase
    end
    // A new event beats a clear by read in the same cycle
    st_nxt.flags = st_nxt.flags | ev;
    // Software reset spares control, manual switch and manual charge
    if (st_r.soft_pulse)
    begin
      st_nxt.flags = `FLAGS_RESET;
      st_nxt.mic = `MIC_RESET;
      st_nxt.state = ST_STANDBY;
    end
    // Without battery the registers stay at their defaults
    if (!pins_s.battery_valid)
    begin
      st_nxt.ctrl = `CTRL_RESET;
      st_nxt.flags = `FLAGS_RESET;
      st_nxt.mansw = `MANSW_RESET;
      st_nxt.chg = `CHG_RESET;
      st_nxt.mic = `MIC_RESET;
    end
    // Hardware reset restores every register and returns to standby
    if (hw_rst)
    begin
      st_nxt.ctrl = `CTRL_RESET;
      st_nxt.flags = `FLAGS_RESET;
      st_nxt.mansw = `MANSW_RESET;
      st_nxt.chg = `CHG_RESET;
      st_nxt.mic = `MIC_RESET;
      st_nxt.state = ST_STANDBY;
      st_nxt.soft_pulse = 1'b0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      st_r <= CORE_RESET;
    else
      st_r <= st_nxt;
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Manual host-one routing only once discovery has finished on an attached device; the manual pass transistor bit applies at once
  assign man_active = st_r.ctrl[`CTRL_MAN_SW_EN_BIT] & usb_discovery_done
    & (st_r.state == ST_ATTACHED);

  always_comb
  begin
    switches.vbus_fet_on = (st_r.state == ST_ATTACHED) & pins_s.cable_valid
      & ~(st_r.ctrl[`CTRL_MAN_SW_EN_BIT] & ~st_r.mansw[`MANSW_VBUS_FET_BIT]);
    switches.host_one_dplus = (st_r.state == ST_ATTACHED)
      & (man_active ? st_r.mansw[`MANSW_HOST_ONE_BIT] : usb_route_req);
    switches.host_one_dminus = switches.host_one_dplus;
    switches.mic_to_cable_supply = (st_r.state == ST_ATTACHED)
      & st_r.mic[`MIC_ENABLE_BIT] & ~st_r.mic[`MIC_MONO_BIT];
    switches.mic_to_connector_dplus = (st_r.state == ST_ATTACHED)
      & st_r.mic[`MIC_ENABLE_BIT] & st_r.mic[`MIC_MONO_BIT];
    switches.mic_overvoltage_enable = st_r.mic[`MIC_OVERVOLTAGE_EN_BIT];
  end

  // Push-pull, high whenever masked, idle or without I/O supply
  assign irq_out_n = ~((|st_r.flags) & ~st_r.ctrl[`CTRL_INT_MASK_BIT]
    & pins_s.io_valid);
  assign reg_rdata = st_r.rdata;
  assign reg_rvalid = st_r.rvalid;
  assign standby = (st_r.state == ST_STANDBY);
  assign hw_reset_pulse = hw_rst;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  sequence s_soft_write;
    power.comm_enable && reg_req.wr && reg_req.addr == `ADDR_CONTROL
      && reg_req.wdata[`CTRL_SOFT_RESET_BIT] && !hw_rst && pins_s.battery_valid;
  endsequence

  sequence s_flag_read;
    power.comm_enable && reg_req.rd && reg_req.addr == `ADDR_INT_FLAGS
      && ev == 8'h00 && !hw_rst && !st_r.soft_pulse;
  endsequence

  a_hw_defaults: assert property (hw_rst |=> st_r.ctrl == `CTRL_RESET
    && st_r.mansw == `MANSW_RESET && st_r.flags == 8'h00 && standby)
    else $error("hardware reset did not restore defaults");
  a_io_fall_reset: assert property (io_fall |-> hw_reset_pulse ##1 st_r.ctrl[0])
    else $error("I/O supply fall did not reset");
  a_soft_trigger: assert property (s_soft_write |=> st_r.soft_pulse
    ##1 (st_r.mic == `MIC_RESET || !pins_s.battery_valid))
    else $error("soft reset not applied");
  a_soft_keeps_ctrl: assert property (st_r.soft_pulse && !hw_rst && !reg_req.wr
    && pins_s.battery_valid |=> st_r.ctrl == $past(st_r.ctrl))
    else $error("soft reset touched control");
  a_mask_holds_high: assert property (st_r.ctrl[`CTRL_INT_MASK_BIT] |-> irq_out_n)
    else $error("interrupt asserted while masked");
  a_event_irq_low: assert property ((|ev) && !st_r.ctrl[`CTRL_INT_MASK_BIT]
    && pins_s.io_valid && pins_s.battery_valid && !hw_rst && !st_r.soft_pulse
    && !reg_req.wr |=> (!irq_out_n || !pins_s.io_valid))
    else $error("event did not pull interrupt low");
  a_read_releases: assert property (s_flag_read |=> irq_out_n)
    else $error("flag read did not release interrupt");
  a_charge_gate: assert property (power.charge_enable |-> pins_s.cable_valid)
    else $error("charging without cable supply");
  a_fet_manual_open: assert property (st_r.ctrl[`CTRL_MAN_SW_EN_BIT]
    && !st_r.mansw[`MANSW_VBUS_FET_BIT] |-> !switches.vbus_fet_on)
    else $error("pass transistor on against manual setting");
  a_comm_gate: assert property (!power.comm_enable && reg_req.wr && !hw_rst
    && pins_s.battery_valid && !st_r.soft_pulse |=> st_r.ctrl == $past(st_r.ctrl))
    else $error("write taken without I/O supply");
  a_manual_route: assert property (man_active |-> switches.host_one_dplus
    == st_r.mansw[`MANSW_HOST_ONE_BIT])
    else $error("manual switch setting not applied");

  // ****************************************
  // Checks on supplies, reset sources and routing
  // ****************************************
  sequence s_soft_apply;
    st_r.soft_pulse && !hw_rst && !reg_req.wr && pins_s.battery_valid;
  endsequence

  sequence s_attach_seen;
    standby && attach_now && !hw_rst && !st_r.soft_pulse && pins_s.battery_valid;
  endsequence

  // Every hardware source must reach the reset pulse
  a_bus_low_reset: assert property (bus_low_fire |-> hw_reset_pulse)
    else $error("bus low expiry did not reset");
  a_por_battery: assert property (pins_s.battery_valid && !st_r.prev.battery_valid
    && !pins_s.cable_valid |-> hw_reset_pulse)
    else $error("battery rise did not reset");
  a_por_cable: assert property (pins_s.cable_valid && !st_r.prev.cable_valid
    && pins_s.battery_low |-> hw_reset_pulse)
    else $error("cable rise on low battery did not reset");

  // Soft reset spares switch and charge settings, yet drops back to standby
  a_soft_spares: assert property (s_soft_apply
    |=> st_r.mansw == $past(st_r.mansw) && st_r.chg == $past(st_r.chg))
    else $error("soft reset touched manual registers");
  a_soft_standby: assert property (st_r.soft_pulse |=> standby)
    else $error("soft reset left attach state");

  // Without battery the host settings cannot be kept
  a_cable_defaults: assert property (!pins_s.battery_valid
    |=> st_r.ctrl == `CTRL_RESET && st_r.mansw == `MANSW_RESET
    && st_r.chg == `CHG_RESET)
    else $error("registers left default without battery");

  // Supply combinations and the register port
  a_no_supply_off: assert property (!pins_s.cable_valid && !pins_s.battery_valid
    |-> !power.detect_enable && !power.charge_enable && !power.comm_enable)
    else $error("function enabled without supply");
  a_read_answer: assert property (power.comm_enable && reg_req.rd |=> reg_rvalid)
    else $error("read without answer");
  a_read_refused: assert property (!power.comm_enable && reg_req.rd
    |=> !reg_rvalid)
    else $error("read answered without I/O supply");
  a_irq_needs_io: assert property (!pins_s.io_valid |-> irq_out_n)
    else $error("interrupt driven without I/O supply");

  // Routing: nothing closes in standby, the pass transistor follows attach
  a_standby_open: assert property (standby |-> !switches.vbus_fet_on
    && !switches.host_one_dplus && !switches.mic_to_cable_supply
    && !switches.mic_to_connector_dplus)
    else $error("switch closed in standby");
  a_fet_on_attach: assert property (!standby && pins_s.cable_valid
    && !st_r.ctrl[`CTRL_MAN_SW_EN_BIT] |-> switches.vbus_fet_on)
    else $error("pass transistor open on attach");
  a_mic_one_route: assert property (!(switches.mic_to_cable_supply
    && switches.mic_to_connector_dplus))
    else $error("microphone routed to both pins");
  a_attach_flag: assert property (s_attach_seen |=> st_r.flags[`FLAG_ATTACH_BIT])
    else $error("attach not recorded");
endmodule : reset_power_interrupt_core
`default_nettype wire

// ==== design/rpi_defines.svh ====
`ifndef RPI_DEFINES_SVH
`define RPI_DEFINES_SVH

// ****************************************
// Register offsets
// ****************************************
`define ADDR_CONTROL 8'h02
`define ADDR_INT_FLAGS 8'h03
`define ADDR_MANUAL_SWITCH 8'h13
`define ADDR_CHARGE_MANUAL 8'h14
`define ADDR_MIC_CONFIG 8'h15

// ****************************************
// Field positions
// ****************************************
`define CTRL_INT_MASK_BIT 0
`define CTRL_MAN_SW_EN_BIT 2
`define CTRL_SOFT_RESET_BIT 6
`define MANSW_HOST_ONE_BIT 0
`define MANSW_VBUS_FET_BIT 1
`define CHG_INHIBIT_BIT 0
`define MIC_OVERVOLTAGE_EN_BIT 0
`define MIC_ENABLE_BIT 1
`define MIC_MONO_BIT 2
`define FLAG_ATTACH_BIT 0
`define FLAG_DETACH_BIT 1
`define FLAG_VBUS_CHG_BIT 2
`define FLAG_ID_CHG_BIT 3

// ****************************************
// Reset values
// ****************************************
`define CTRL_RESET 8'h05
`define FLAGS_RESET 8'h00
`define MANSW_RESET 8'h03
`define CHG_RESET 8'h00
`define MIC_RESET 8'h00

// ****************************************
// Timing
// ****************************************
`define REF_CLK_HZ 50000000
`define BUS_LOW_RESET_MS 30
`define BUS_LOW_RESET_CYCLES ((`BUS_LOW_RESET_MS * `REF_CLK_HZ) / 1000)

`endif

// ==== design/rpi_pkg.sv ====
// ****************************************
// Shared types
// ****************************************
`default_nettype none
package rpi_pkg;

  typedef logic [23:0] timer_cnt_t;

  // Raw supply comparators and bus pins, all asynchronous
  typedef struct packed {
    logic cable_valid;
    logic battery_valid;
    logic battery_low;
    logic io_valid;
    logic scl;
    logic sda;
    logic id_float;
  } supply_pins_s;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic charge_enable;
    logic detect_enable;
    logic comm_enable;
    logic illegal_supply;
    logic cable_powered;
  } power_state_s;

  typedef struct packed {
    logic vbus_fet_on;
    logic host_one_dplus;
    logic host_one_dminus;
    logic mic_to_cable_supply;
    logic mic_to_connector_dplus;
    logic mic_overvoltage_enable;
  } switch_ctrl_s;

  typedef enum logic {ST_STANDBY, ST_ATTACHED} attach_state_e;

  typedef struct packed {
    timer_cnt_t cnt;
    logic fired;
  } bus_timer_s;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] flags;
    logic [7:0] mansw;
    logic [7:0] chg;
    logic [7:0] mic;
    attach_state_e state;
    supply_pins_s prev;
    logic [7:0] rdata;
    logic rvalid;
    logic soft_pulse;
  } core_state_s;

endpackage : rpi_pkg
`default_nettype wire

// ==== testbench/host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Baseband processor: register master, bus-reset driver
// ****************************************
module host_model (
  input wire logic ref_clk, // System clock
  input wire logic [7:0] reg_rdata, // Read data from block
  input wire logic reg_rvalid, // Read data valid pulse
  output rpi_pkg::reg_req_s reg_req, // Register request
  output logic scl, // Serial clock line
  output logic sda // Serial data line
);
  import rpi_pkg::*;

  // Idle: lines pulled up, nothing requested
  initial
  begin
    reg_req = '0;
    scl = 1'b1;
    sda = 1'b1;
  end

  // One write; caller sits just after an edge
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    reg_req.wr = 1'b1;
    reg_req.addr = addr;
    reg_req.wdata = data;
    @(posedge ref_clk);
    #1;
    reg_req.wr = 1'b0;
    // Released fields carry junk so stale values never pass
    reg_req.addr = ~addr;
    reg_req.wdata = ~data;
    @(posedge ref_clk);
    #1;
  endtask : write_reg

  // One read; the answer is taken in the cycle after the request edge
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data, output logic ok);
    reg_req.rd = 1'b1;
    reg_req.addr = addr;
    @(posedge ref_clk);
    #1;
    reg_req.rd = 1'b0;
    reg_req.addr = ~addr;
    ok = reg_rvalid;
    data = reg_rdata;
    @(posedge ref_clk);
    #1;
  endtask : read_reg

  // Both lines low for n cycles, then back to the pull-up level
  task automatic hold_bus_low(input int unsigned n);
    scl = 1'b0;
    sda = 1'b0;
    repeat (n) @(posedge ref_clk);
    #1;
    scl = 1'b1;
    sda = 1'b1;
  endtask : hold_bus_low
endmodule : host_model
`default_nettype wire

// ==== testbench/reset_power_interrupt_core_test.sv ====
`timescale 1ns/10ps
`default_nettype none
module reset_power_interrupt_core_test;
  import rpi_pkg::*;

  logic ref_clk, resetn, cable, bat, blow, io, idf, scl, sda;
  logic id_code_change, usb_discovery_done, usb_route_req;
  supply_pins_s pins;
  reg_req_s reg_req;
  logic [7:0] reg_rdata, rd_data;
  logic reg_rvalid, irq_out_n, standby, hw_reset_pulse, rd_ok;
  power_state_s power;
  switch_ctrl_s switches;
  int unsigned num_errors, checks, hw_resets, hw_base, cycles, i;

  assign pins = {cable, bat, blow, io, scl, sda, idf};

  // ****************************************
  // Block, host and clock
  // ****************************************
  // Short bus-low count keeps the run brief
  reset_power_interrupt_core #(.BUS_LOW_CYCLES(24'd20)) dut (
    .ref_clk(ref_clk), .resetn(resetn), .pins(pins), .id_code_change(id_code_change),
    .usb_discovery_done(usb_discovery_done), .usb_route_req(usb_route_req),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .irq_out_n(irq_out_n), .power(power), .switches(switches), .standby(standby),
    .hw_reset_pulse(hw_reset_pulse));

  host_model host (.ref_clk(ref_clk), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .reg_req(reg_req), .scl(scl), .sda(sda));

  // 50 MHz clock
  always #10 ref_clk = ~ref_clk;

  // Count internal resets and cut a hang short
  always @(posedge ref_clk)
  begin
    if (hw_reset_pulse === 1'b1)
      hw_resets++;
    cycles++;
    if (cycles == 3000)
    begin
      num_errors++;
      stop_test();
    end
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Pins pass two flops; four edges leave margin
  task automatic settle();
    repeat (4) @(posedge ref_clk);
    #1;
  endtask : settle

  task automatic rd_expect(input logic [7:0] addr, input logic [7:0] exp);
    host.read_reg(addr, rd_data, rd_ok);
    check({7'h00, rd_ok}, 8'h01);
    check(rd_data, exp);
  endtask : rd_expect

  task automatic stop_test();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    ref_clk = 1'b0;
    resetn = 1'b0;
    // Id pin floats while nothing is plugged in
    {cable, bat, blow, io, idf} = 5'h01;
    {id_code_change, usb_discovery_done, usb_route_req} = 3'h0;
    {num_errors, checks, hw_resets, cycles} = '0;
    repeat (2) @(posedge ref_clk);
    #1;
    resetn = 1'b1;
    check({7'h00, irq_out_n}, 8'h01);
    check({7'h00, standby}, 8'h01);
    check({2'h0, switches}, 8'h00);
    // Battery and processor supply rise together
    bat = 1'b1;
    io = 1'b1;
    usb_route_req = 1'b1;
    settle();
    check(8'(hw_resets), 8'h01);
    check({3'h0, power}, 8'h0C);
    rd_expect(8'h02, 8'h05);
    rd_expect(8'h03, 8'h00);
    rd_expect(8'h13, 8'h03);
    rd_expect(8'h40, 8'h00);
    // Cable attach while masked
    cable = 1'b1;
    settle();
    check(8'(hw_resets), 8'h01);
    check({7'h00, irq_out_n}, 8'h01);
    check({7'h00, standby}, 8'h00);
    check({2'h0, switches}, 8'h38);
    check({3'h0, power}, 8'h1C);
    usb_route_req = 1'b0;
    usb_discovery_done = 1'b1;
    settle();
    check({2'h0, switches}, 8'h38);
    // Unmasking raises the stored events; manual mode stays on
    host.write_reg(8'h02, 8'h04);
    check({7'h00, irq_out_n}, 8'h00);
    rd_expect(8'h03, 8'h05);
    check({7'h00, irq_out_n}, 8'h01);
    rd_expect(8'h03, 8'h00);
    id_code_change = 1'b1;
    @(posedge ref_clk);
    #1;
    id_code_change = 1'b0;
    @(posedge ref_clk);
    #1;
    check({7'h00, irq_out_n}, 8'h00);
    rd_expect(8'h03, 8'h08);
    // Manual register opens the pass transistor and host one while manual mode is on; microphone routes still close
    host.write_reg(8'h13, 8'h00);
    check({2'h0, switches}, 8'h00);
    host.write_reg(8'h15, 8'h07);
    check({2'h0, switches}, 8'h03);
    host.write_reg(8'h15, 8'h03);
    check({2'h0, switches}, 8'h05);
    host.write_reg(8'h14, 8'h01);
    // Software reset spares three registers only
    host.write_reg(8'h02, 8'h40);
    settle();
    rd_expect(8'h02, 8'h00);
    rd_expect(8'h13, 8'h00);
    rd_expect(8'h14, 8'h01);
    rd_expect(8'h15, 8'h00);
    // Bus-low reset: a short stretch must not count
    hw_base = hw_resets;
    host.hold_bus_low(10);
    settle();
    check(8'(hw_resets), 8'(hw_base));
    host.hold_bus_low(30);
    settle();
    check(8'(hw_resets), 8'(hw_base + 1));
    rd_expect(8'h02, 8'h05);
    rd_expect(8'h13, 8'h03);
    rd_expect(8'h14, 8'h00);
    // Processor supply falls: reset, no access
    io = 1'b0;
    settle();
    check(8'(hw_resets), 8'(hw_base + 2));
    host.read_reg(8'h02, rd_data, rd_ok);
    check({7'h00, rd_ok}, 8'h00);
    check({7'h00, irq_out_n}, 8'h01);
    // Cable-powered: writes lost, defaults held
    io = 1'b1;
    bat = 1'b0;
    settle();
    host.write_reg(8'h02, 8'h00);
    rd_expect(8'h02, 8'h05);
    // Cable rise with low battery
    cable = 1'b0;
    blow = 1'b1;
    settle();
    hw_base = hw_resets;
    cable = 1'b1;
    settle();
    check(8'(hw_resets), 8'(hw_base + 1));
    blow = 1'b0;
    // Every supply combination
    for (i = 0; i < 8; i++)
    begin
      {cable, bat, io} = 3'(i);
      settle();
      check({3'h0, power}, {3'h0, cable, cable | bat, io & (cable | bat),
        io & ~cable & ~bat, cable & ~bat});
    end
    stop_test();
  end
endmodule : reset_power_interrupt_core_test
`default_nettype wire
